// file: verilog/power_mode_controller.sv
// power mode controller: mode sequencing, clock gating, bias select
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module power_mode_controller #(
  parameter int snooze_wake_cycles = pmc_pkg::snooze_wake_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic any_interrupt,
  input wire logic [5:0] wake_event,
  input wire logic reset_pin_n,
  input wire logic power_on_reset,
  input wire logic other_reset,
  output logic core_clk_en,
  output logic [7:0] periph_clk_en,
  output logic fast_osc_a_en,
  output logic fast_osc_b_en,
  output logic regulator_low_bias,
  output logic power_nets_off,
  output logic pin_retain,
  output logic timer_slow_clk_en,
  output logic core_reset,
  output logic [2:0] mode_out
);
  localparam int tw = 20;

  pmc_pkg::mode_t mode;
  pmc_pkg::mode_t next_mode;
  logic [pmc_pkg::periph_count-1:0] periph_enable;
  logic deep_off_select;
  logic timer_keep;
  logic [1:0] clock_src;
  logic [1:0] saved_clock_src;
  logic idle_req;
  logic suspend_req;
  logic snooze_req;
  logic timer_load;
  logic [tw-1:0] timer_count;
  logic timer_done;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  pmc_axil_slave bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  // address decode
  wire wa_pc0 = wr_addr == pmc_pkg::power_ctrl_zero_addr;
  wire wa_pc1 = wr_addr == pmc_pkg::power_ctrl_one_addr;
  wire wa_reg = wr_addr == pmc_pkg::regulator_ctrl_addr;
  wire wa_per = wr_addr == pmc_pkg::periph_enable_addr;
  wire wa_clk = wr_addr == pmc_pkg::clock_ctrl_addr;
  wire wa_sts = wr_addr == pmc_pkg::status_addr;
  assign wr_ok = wa_pc0 || wa_pc1 || wa_reg || wa_per || wa_clk || wa_sts;
  wire in_normal = mode == pmc_pkg::mode_normal;
  // sleep requests only count from normal mode
  wire set_idle = wr_en && wa_pc0 && in_normal
    && wr_data[pmc_pkg::idle_bit];
  wire set_stop = wr_en && wa_pc0 && in_normal
    && wr_data[pmc_pkg::stop_bit];
  wire set_suspend = wr_en && wa_pc1 && in_normal
    && wr_data[pmc_pkg::suspend_bit];
  wire set_snooze = wr_en && wa_pc1 && in_normal
    && wr_data[pmc_pkg::snooze_bit];

  // read mux: the status word shows live mode and saved clock source
  wire [31:0] rd_pc0 = {30'h0, 1'b0, idle_req};
  wire [31:0] rd_pc1 = {30'h0, snooze_req, suspend_req};
  wire [31:0] rd_reg = {31'h0, deep_off_select};
  wire [31:0] rd_per = {24'h0, periph_enable};
  wire [31:0] rd_sts = {24'h0, timer_keep, saved_clock_src, 2'h0, mode};
  wire [31:0] rd_clk = {30'h0, clock_src};
  assign rd_ok = rd_addr == pmc_pkg::power_ctrl_zero_addr
    || rd_addr == pmc_pkg::power_ctrl_one_addr
    || rd_addr == pmc_pkg::regulator_ctrl_addr
    || rd_addr == pmc_pkg::periph_enable_addr
    || rd_addr == pmc_pkg::status_addr
    || rd_addr == pmc_pkg::clock_ctrl_addr;
  assign rd_data =
    rd_addr == pmc_pkg::power_ctrl_zero_addr ? rd_pc0 :
    rd_addr == pmc_pkg::power_ctrl_one_addr ? rd_pc1 :
    rd_addr == pmc_pkg::regulator_ctrl_addr ? rd_reg :
    rd_addr == pmc_pkg::periph_enable_addr ? rd_per :
    rd_addr == pmc_pkg::status_addr ? rd_sts :
    rd_addr == pmc_pkg::clock_ctrl_addr ? rd_clk : 32'h0000_0000;

  // ----------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------
  wire deep_wake = |wake_event;
  // stop leaves on any reset, shutdown only on pin or power-on
  wire stop_exit = !reset_pin_n || power_on_reset || other_reset;
  wire shutdown_exit = !reset_pin_n || power_on_reset;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      periph_enable <= pmc_pkg::periph_enable_reset;
      deep_off_select <= 1'b0;
      timer_keep <= 1'b0;
      clock_src <= pmc_pkg::clock_src_reset;
    end
    else if (wr_en)
    begin
      if (wa_per)
        periph_enable <= wr_data;
      if (wa_reg)
        deep_off_select <= wr_data[pmc_pkg::deep_off_bit];
      if (wa_sts)
        timer_keep <= wr_data[pmc_pkg::timer_keep_bit];
      if (wa_clk)
        clock_src <= wr_data[1:0];
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  // deep_off_select at the stop write picks stop or shutdown
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      pmc_pkg::mode_normal:
        if (set_stop)
          next_mode = deep_off_select ? pmc_pkg::mode_shutdown
            : pmc_pkg::mode_stop;
        else if (set_snooze)
          next_mode = pmc_pkg::mode_snooze;
        else if (set_suspend)
          next_mode = pmc_pkg::mode_suspend;
        else if (set_idle)
          next_mode = pmc_pkg::mode_idle;
      pmc_pkg::mode_idle:
        // any pending interrupt ends idle; the wake state adds the settle
        if (any_interrupt)
          next_mode = pmc_pkg::mode_wake;
      pmc_pkg::mode_suspend, pmc_pkg::mode_snooze:
        if (deep_wake)
          next_mode = pmc_pkg::mode_wake;
      pmc_pkg::mode_wake:
        if (timer_done)
          next_mode = pmc_pkg::mode_normal;
      pmc_pkg::mode_stop:
        if (stop_exit)
          next_mode = pmc_pkg::mode_normal;
      pmc_pkg::mode_shutdown:
        if (shutdown_exit)
          next_mode = pmc_pkg::mode_normal;
      default:
        next_mode = pmc_pkg::mode_normal;
    endcase
  end

  // wake length depends on which sleep mode is being left
  always_comb
  begin
    timer_load = 1'b0;
    timer_count = tw'(pmc_pkg::idle_wake_cycles - 1);
    if (next_mode == pmc_pkg::mode_wake && mode != pmc_pkg::mode_wake)
    begin
      timer_load = 1'b1;
      if (mode == pmc_pkg::mode_suspend)
        timer_count = tw'(pmc_pkg::suspend_wake_cycles - 1);
      else if (mode == pmc_pkg::mode_snooze)
        timer_count = tw'(snooze_wake_cycles - 1);
    end
  end

  pmc_wake_timer #(.width(tw)) wake_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= pmc_pkg::mode_normal;
      idle_req <= 1'b0;
      suspend_req <= 1'b0;
      snooze_req <= 1'b0;
      saved_clock_src <= pmc_pkg::clock_src_fast_osc_a;
    end
    else
    begin
      mode <= next_mode;
      if (set_idle)
        idle_req <= 1'b1;
      if (set_suspend)
        suspend_req <= 1'b1;
      if (set_snooze)
        snooze_req <= 1'b1;
      if (next_mode != pmc_pkg::mode_normal && in_normal)
        saved_clock_src <= clock_src;
      // request bits self-clear as the wake state hands back to normal
      if (mode == pmc_pkg::mode_wake && timer_done)
      begin
        idle_req <= 1'b0;
        suspend_req <= 1'b0;
        snooze_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock, oscillator and regulator controls
  // ----------------------------------------------------------------
  wire deep_sleep = next_mode == pmc_pkg::mode_suspend
    || next_mode == pmc_pkg::mode_snooze;
  wire powered_off = next_mode == pmc_pkg::mode_stop
    || next_mode == pmc_pkg::mode_shutdown;
  wire core_run = next_mode == pmc_pkg::mode_normal;
  wire periph_run = core_run || next_mode == pmc_pkg::mode_idle
    || next_mode == pmc_pkg::mode_wake;

  // registered so every output comes straight from a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_clk_en <= 1'b1;
      periph_clk_en <= pmc_pkg::periph_enable_reset;
      fast_osc_a_en <= 1'b1;
      fast_osc_b_en <= 1'b1;
      regulator_low_bias <= 1'b0;
      power_nets_off <= 1'b0;
      pin_retain <= 1'b0;
      timer_slow_clk_en <= 1'b0;
      core_reset <= 1'b0;
      mode_out <= 3'h0;
    end
    else
    begin
      core_clk_en <= core_run;
      periph_clk_en <= periph_run ? periph_enable : 8'h00;
      fast_osc_a_en <= !deep_sleep && !powered_off;
      fast_osc_b_en <= !deep_sleep && !powered_off;
      regulator_low_bias <= next_mode == pmc_pkg::mode_snooze;
      power_nets_off <= powered_off;
      pin_retain <= powered_off;
      timer_slow_clk_en <= deep_sleep && timer_keep;
      core_reset <= mode == pmc_pkg::mode_stop && stop_exit
        || mode == pmc_pkg::mode_shutdown && shutdown_exit;
      mode_out <= next_mode;
    end
  end
endmodule : power_mode_controller
`default_nettype wire

// file: verilog/pmc_pkg.sv
// constants and types shared by the power mode controller
package pmc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] power_ctrl_zero_addr = 8'h00;
  localparam logic [7:0] power_ctrl_one_addr = 8'h04;
  localparam logic [7:0] regulator_ctrl_addr = 8'h08;
  localparam logic [7:0] periph_enable_addr = 8'h0c;
  localparam logic [7:0] status_addr = 8'h10;
  localparam logic [7:0] clock_ctrl_addr = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int idle_bit = 0;
  localparam int stop_bit = 1;
  localparam int suspend_bit = 0;
  localparam int snooze_bit = 1;
  localparam int deep_off_bit = 0;
  localparam int timer_keep_bit = 0;
  localparam int periph_count = 8;
  localparam logic [7:0] periph_enable_reset = 8'hff;
  localparam logic [1:0] clock_src_reset = 2'h0;
  localparam logic [1:0] clock_src_fast_osc_a = 2'h0;

  // wake source index
  localparam int wake_timer4 = 0;
  localparam int wake_spi = 1;
  localparam int wake_i2c = 2;
  localparam int wake_port_match = 3;
  localparam int wake_comparator = 4;
  localparam int wake_config_logic_unit = 5;
  localparam int wake_count = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clk_period_ps = 50000;
  localparam int idle_wake_cycles = 2;
  localparam int suspend_wake_ps = 170000;
  localparam int snooze_wake_ps = 12000000;
  // typical figures: whole cycles rounded down, never below one
  localparam int suspend_wake_cycles =
    (suspend_wake_ps / clk_period_ps) < 1 ? 1 :
    (suspend_wake_ps / clk_period_ps);
  localparam int snooze_wake_cycles =
    (snooze_wake_ps / clk_period_ps) < 1 ? 1 :
    (snooze_wake_ps / clk_period_ps);

  typedef enum logic [2:0] {
    mode_normal = 3'b000,
    mode_idle = 3'b001,
    mode_suspend = 3'b011,
    mode_snooze = 3'b010,
    mode_wake = 3'b110,
    mode_stop = 3'b111,
    mode_shutdown = 3'b101
  } mode_t;

endpackage : pmc_pkg

// file: verilog/pmc_wake_timer.sv
// down counter that times a wake-up settling interval
`timescale 1ns/10ps
`default_nettype none
module pmc_wake_timer #(
  parameter int width = 9
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [width-1:0] count,
  output logic done
);
  logic [width-1:0] remain;
  logic running;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // done pulses the cycle the count runs out
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remain <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else if (load)
    begin
      remain <= count;
      running <= 1'b1;
      done <= 1'b0;
    end
    else
    begin
      done <= running && (remain <= width'(1));
      if (running && remain <= width'(1))
        running <= 1'b0;
      if (running && remain != '0)
        remain <= remain - width'(1);
    end
  end
endmodule : pmc_wake_timer
`default_nettype wire

// file: verilog/pmc_axil_slave.sv
// axi4-lite register port: one write and one read at a time
`timescale 1ns/10ps
`default_nettype none
module pmc_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  logic have_aw;
  logic have_w;
  logic [7:0] aw_hold;
  logic [7:0] w_hold;
  logic w_lane0;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = have_aw && have_w && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // only byte lane zero carries register bits
  assign wr_en = wr_fire && w_lane0;
  assign wr_addr = aw_hold;
  assign wr_data = w_hold;
  assign rd_en = ar_take;
  assign rd_addr = s_axi_araddr;

  // ----------------------------------------------------------------
  // write channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_hold <= 8'h00;
      w_hold <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !have_aw && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !have_w && !w_take && !s_axi_bvalid;
      if (aw_take)
      begin
        have_aw <= 1'b1;
        aw_hold <= s_axi_awaddr;
      end
      if (w_take)
      begin
        have_w <= 1'b1;
        w_hold <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2; // slverr when unmapped
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pmc_axil_slave
`default_nettype wire

// file: verification/power_mode_controller_sva.sv
// assertion checker for the power mode controller ports
`timescale 1ns/10ps
`default_nettype none
module pmc_checker #(
  parameter int snooze_wake_cycles = pmc_pkg::snooze_wake_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic any_interrupt,
  input wire logic [5:0] wake_event,
  input wire logic reset_pin_n,
  input wire logic power_on_reset,
  input wire logic other_reset,
  input wire logic core_clk_en,
  input wire logic [7:0] periph_clk_en,
  input wire logic fast_osc_a_en,
  input wire logic fast_osc_b_en,
  input wire logic regulator_low_bias,
  input wire logic power_nets_off,
  input wire logic pin_retain,
  input wire logic timer_slow_clk_en,
  input wire logic core_reset,
  input wire logic [2:0] mode_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // counter bounds the wake settle; a delay range would unroll 240
  logic [15:0] wake_cnt;
  wire logic asleep;
  wire logic powered_off;
  assign asleep = mode_out == pmc_pkg::mode_suspend ||
    mode_out == pmc_pkg::mode_snooze;
  assign powered_off = mode_out == pmc_pkg::mode_stop ||
    mode_out == pmc_pkg::mode_shutdown;

  // cycles spent in the wake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn || mode_out != pmc_pkg::mode_wake) wake_cnt <= 16'h0000;
    else wake_cnt <= wake_cnt + 16'h0001;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_normal_core_on: assert property (
    mode_out == pmc_pkg::mode_normal |-> core_clk_en)
    else $error("core clock off in normal mode");
  a_idle_core_halt: assert property (
    mode_out == pmc_pkg::mode_idle |-> !core_clk_en)
    else $error("core clock running in idle");
  a_idle_wake_time: assert property (
    mode_out == pmc_pkg::mode_idle && any_interrupt
    |-> ##[2:3] mode_out == pmc_pkg::mode_normal)
    else $error("idle wake not within three cycles");
  a_sleep_clocks_off: assert property (
    asleep |-> !core_clk_en && periph_clk_en == 8'h00 &&
    !fast_osc_a_en && !fast_osc_b_en)
    else $error("clock or oscillator running while asleep");
  a_sleep_bias: assert property (
    asleep |-> regulator_low_bias == (mode_out == pmc_pkg::mode_snooze))
    else $error("wrong regulator bias while asleep");
  a_slow_timer_sleep: assert property (
    timer_slow_clk_en |-> asleep)
    else $error("slow timer clock outside sleep");
  a_sleep_wakes: assert property (
    asleep && |wake_event |=> mode_out == pmc_pkg::mode_wake)
    else $error("wake event ignored while asleep");
  a_wake_no_reset: assert property (
    mode_out == pmc_pkg::mode_wake |-> !core_reset)
    else $error("core reset during wake");
  a_suspend_wake_time: assert property (
    mode_out == pmc_pkg::mode_suspend && |wake_event
    |-> ##[3:6] mode_out == pmc_pkg::mode_normal)
    else $error("suspend wake too slow or too fast");
  a_wake_bounded: assert property (
    wake_cnt <= snooze_wake_cycles + 2)
    else $error("wake state lasts too long");
  a_off_power_nets: assert property (
    powered_off |-> power_nets_off && pin_retain)
    else $error("power nets on or pins released when off");
  a_stop_exit: assert property (
    mode_out == pmc_pkg::mode_stop && other_reset |-> ##[1:2] core_reset)
    else $error("stop not left on reset");
  a_shutdown_holds: assert property (
    mode_out == pmc_pkg::mode_shutdown && reset_pin_n && !power_on_reset
    |=> mode_out == pmc_pkg::mode_shutdown)
    else $error("shutdown left without pin or power-on reset");

  c_snooze_wake: cover property (
    mode_out == pmc_pkg::mode_snooze ##1 mode_out == pmc_pkg::mode_wake);
  c_idle_wake: cover property (
    mode_out == pmc_pkg::mode_idle ##1 mode_out == pmc_pkg::mode_wake);
  c_stop_exit: cover property (
    mode_out == pmc_pkg::mode_stop ##1 mode_out == pmc_pkg::mode_normal);
endmodule : pmc_checker

bind power_mode_controller pmc_checker #(
  .snooze_wake_cycles(snooze_wake_cycles)
) u_checker (.*);
`default_nettype wire

// file: verification/test_power_mode_controller.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_controller;
  // short snooze settle keeps the run brief
  localparam int snooze_cycles = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, any_interrupt;
  logic reset_pin_n, power_on_reset, other_reset, core_clk_en;
  logic fast_osc_a_en, fast_osc_b_en, regulator_low_bias;
  logic power_nets_off, pin_retain, timer_slow_clk_en, core_reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr, periph_clk_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [5:0] wake_event;
  logic [2:0] mode_out, sleep_mode;
  logic saw_reset;
  int num_errors, comparisons, n, i, lo;

  power_mode_controller #(.snooze_wake_cycles(snooze_cycles)) u_dut (.*);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // remembers any core reset pulse between clears
  always @(posedge aclk)
    if (core_reset === 1'b1) saw_reset <= 1'b1;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // address and data offered together, bready held until answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // edges until the mode appears; bounded so a stuck mode shows up
  task automatic wait_mode(input logic [2:0] m);
    n = 0;
    while (mode_out !== m && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_mode

  // one-cycle pulse on a reset source, then back to rest
  task automatic pulse_reset(input int which);
    @(posedge aclk);
    if (which == 0) other_reset <= 1'b1;
    else if (which == 1) reset_pin_n <= 1'b0;
    else power_on_reset <= 1'b1;
    @(posedge aclk);
    other_reset <= 1'b0;
    reset_pin_n <= 1'b1;
    power_on_reset <= 1'b0;
  endtask : pulse_reset

  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, any_interrupt, power_on_reset} = '0;
    {other_reset, wake_event, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    reset_pin_n = 1'b1;
    saw_reset = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("core clock", core_clk_en, 1'b1);
    check("periph clocks", periph_clk_en, 8'hff);
    check("mode", mode_out, pmc_pkg::mode_normal);
    axi_read(8'h18);
    check("unmapped read", resp, 2'h2);
    axi_write(8'h1c, 32'h0000_0001);
    check("unmapped write", resp, 2'h2);
    // unused peripherals lose their clocks
    axi_write(pmc_pkg::periph_enable_addr, 32'h0000_005a);
    repeat (2) @(posedge aclk);
    check("periph gating", periph_clk_en, 8'h5a);
    // byte lane zero off: answered okay, register untouched
    s_axi_wstrb <= 4'he;
    axi_write(pmc_pkg::periph_enable_addr, 32'h0000_00ff);
    check("lane off resp", resp, 2'h0);
    @(posedge aclk);
    check("lane off", periph_clk_en, 8'h5a);
    s_axi_wstrb <= 4'hf;
    axi_write(pmc_pkg::periph_enable_addr, 32'h0000_00ff);
    // idle and its interrupt wake
    axi_write(pmc_pkg::power_ctrl_zero_addr, 32'h0000_0001);
    wait_mode(pmc_pkg::mode_idle);
    check("idle core", core_clk_en, 1'b0);
    check("idle periph", periph_clk_en, 8'hff);
    any_interrupt <= 1'b1;
    @(posedge aclk);
    any_interrupt <= 1'b0;
    wait_mode(pmc_pkg::mode_normal);
    check("idle wake", n >= 2 && n <= 3, 1'b1);
    axi_read(pmc_pkg::power_ctrl_zero_addr);
    check("idle bit", rd[0], 1'b0);
    // each wake source, alternating suspend and snooze
    axi_write(pmc_pkg::status_addr, 32'h0000_0001);
    axi_write(pmc_pkg::clock_ctrl_addr, 32'h0000_0000);
    for (i = 0; i < pmc_pkg::wake_count; i++)
    begin
      sleep_mode = i[0] ? pmc_pkg::mode_snooze : pmc_pkg::mode_suspend;
      lo = i[0] ? snooze_cycles : pmc_pkg::suspend_wake_cycles;
      axi_write(pmc_pkg::power_ctrl_one_addr, i[0] ? 2 : 1);
      wait_mode(sleep_mode);
      check("sleep mode", mode_out, sleep_mode);
      check("sleep core", core_clk_en, 1'b0);
      check("sleep periph", periph_clk_en, 8'h00);
      check("sleep osc", {fast_osc_a_en, fast_osc_b_en}, 2'h0);
      check("sleep bias", regulator_low_bias, i[0]);
      check("slow timers", timer_slow_clk_en, 1'b1);
      wake_event[i] <= 1'b1;
      @(posedge aclk);
      wake_event <= 6'h00;
      wait_mode(pmc_pkg::mode_normal);
      check("wake time", n >= lo && n <= lo + 3, 1'b1);
      axi_read(pmc_pkg::power_ctrl_one_addr);
      check("sleep bits", rd[1:0], 2'h0);
    end
    check("reset on wake", saw_reset, 1'b0);
    axi_read(pmc_pkg::status_addr);
    check("saved clock", rd[6:5], pmc_pkg::clock_src_fast_osc_a);
    // stop, left on an ordinary reset source
    axi_write(pmc_pkg::regulator_ctrl_addr, 32'h0000_0000);
    axi_write(pmc_pkg::power_ctrl_zero_addr, 32'h0000_0002);
    wait_mode(pmc_pkg::mode_stop);
    check("stop mode", mode_out, pmc_pkg::mode_stop);
    check("stop off", {power_nets_off, pin_retain}, 2'h3);
    pulse_reset(0);
    wait_mode(pmc_pkg::mode_normal);
    repeat (2) @(posedge aclk);
    check("stop exit", {saw_reset, mode_out}, 4'h8);
    // shutdown ignores other resets, leaves on pin or power-on
    for (i = 1; i < 3; i++)
    begin
      axi_write(pmc_pkg::regulator_ctrl_addr, 32'h0000_0001);
      axi_write(pmc_pkg::power_ctrl_zero_addr, 32'h0000_0002);
      wait_mode(pmc_pkg::mode_shutdown);
      pulse_reset(0);
      repeat (4) @(posedge aclk);
      check("shutdown holds", mode_out, pmc_pkg::mode_shutdown);
      check("shutdown off", {power_nets_off, pin_retain}, 2'h3);
      pulse_reset(i);
      wait_mode(pmc_pkg::mode_normal);
      check("shutdown exit", mode_out, pmc_pkg::mode_normal);
    end
    print_verdict();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    print_verdict();
  end
endmodule : test_power_mode_controller
`default_nettype wire
